/* File: hw/usart_command_status_port.sv */
`timescale 1ns/10ps

// Operation
// [R1] After mode word and sync characters, control writes load the command word.
// [R2] External or internal reset returns to expecting a mode word.
// [R3] Command word gives transmit enable, receive enable, error reset, modem outputs.
// [R4] Control reads return the status byte at any time.
// [R5] Status snapshot is frozen while a status read is in progress.
// [R6] Status bits follow their events within 28 clock periods.
// [R7] Status bits mirror output pins, except transmit buffer ready.
// [R8] Host leaves six clocks between writes during mode setup.
// [R9] Master reset bit in the command word triggers an internal reset.
// [R10] Error reset command clears parity, framing and overrun flags.
// [R11] Host writes transmit data only while transmit buffer ready is high.
// [R12] Host spaces writes eight clocks async, sixteen clocks sync.
// [R13] Data reads and writes reach receive and transmit buffers.
module usart_command_status_port #(
   parameter int DATA_W = usart_cmd_pkg::DATA_W
) (
   input  wire logic                        clk_sys_i,
   input  wire logic                        rst_n_i,
   input  wire usart_cmd_pkg::host_bus_type bus_i,
   input  wire logic [7:0]                  rx_data_i,
   input  wire logic                        rx_ready_i,
   input  wire logic                        tx_empty_i,
   input  wire logic                        tx_taken_i,
   input  wire logic                        parity_err_i,
   input  wire logic                        overrun_err_i,
   input  wire logic                        framing_err_i,
   input  wire logic                        sync_detect_i,
   input  wire logic                        dsr_n_i,
   input  wire logic                        cts_n_i,
   output logic [7:0]                       data_o,
   output logic                             data_oe_n_o,
   output logic [7:0]                       mode_word_o,
   output logic [7:0]                       sync1_o,
   output logic [7:0]                       sync2_o,
   output logic [7:0]                       tx_data_o,
   output logic                             tx_load_o,
   output logic                             rx_read_o,
   output logic                             status_read_o,
   output logic                             enter_hunt_o,
   output logic                             tx_enable_o,
   output logic                             rx_enable_o,
   output logic                             send_break_o,
   output logic                             dtr_n_o,
   output logic                             rts_n_o,
   output logic                             tx_buffer_ready_o,
   output logic                             rx_ready_o,
   output logic                             tx_empty_o,
   output logic                             sync_detect_o
);

   generate
      if (DATA_W != 8) begin : g_bad_width
         $error("usart_command_status_port serves an 8-bit host bus only");
      end
   endgenerate

   usart_cmd_pkg::state_type s_r;
   usart_cmd_pkg::state_type s_nxt;

   logic wr_now;
   logic rd_now;
   logic wr_end;
   logic rd_end;
   logic sync_mode;
   logic two_sync;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus strobes: a write is committed at its trailing edge, when data is stable

   assign wr_now = ~bus_i.cs_n & ~bus_i.wr_n;
   assign rd_now = ~bus_i.cs_n & ~bus_i.rd_n;
   assign wr_end = s_r.wr_act & ~wr_now;
   assign rd_end = s_r.rd_act & ~rd_now;

   assign sync_mode = (s_r.mode[usart_cmd_pkg::MODE_BAUD_LSB +: 2] ==
                       usart_cmd_pkg::MODE_BAUD_SYNC);
   assign two_sync  = ~s_r.mode[usart_cmd_pkg::MODE_SCS_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_nxt           = s_r;
      s_nxt.tx_load   = 1'b0;
      s_nxt.rx_read   = 1'b0;
      s_nxt.stat_read = 1'b0;
      s_nxt.hunt      = 1'b0;
      s_nxt.wr_act    = wr_now;
      s_nxt.rd_act    = rd_now;

      if (wr_now) begin
         s_nxt.wdata = bus_i.data;
         s_nxt.wr_cd = bus_i.cd;
      end

      // Error flags: clear first so that a same-cycle event still sets
      if (wr_end && s_r.wr_cd && s_r.phase == usart_cmd_pkg::PH_CMD &&
          s_r.wdata[usart_cmd_pkg::CMD_ER_BIT]) begin
         s_nxt.pe = 1'b0; // [R10]
         s_nxt.oe = 1'b0; // [R10]
         s_nxt.fe = 1'b0; // [R10]
      end

      if (tx_taken_i) begin
         s_nxt.buf_empty = 1'b1;
      end

      if (wr_end && s_r.wr_cd) begin
         unique case (s_r.phase)
            usart_cmd_pkg::PH_MODE: begin
               s_nxt.mode = s_r.wdata;
               if (s_r.wdata[usart_cmd_pkg::MODE_BAUD_LSB +: 2] ==
                   usart_cmd_pkg::MODE_BAUD_SYNC) begin
                  s_nxt.phase = usart_cmd_pkg::PH_SYNC1;
               end else begin
                  s_nxt.phase = usart_cmd_pkg::PH_CMD;
               end
            end
            usart_cmd_pkg::PH_SYNC1: begin
               s_nxt.sync1 = s_r.wdata;
               s_nxt.phase = two_sync ? usart_cmd_pkg::PH_SYNC2 : usart_cmd_pkg::PH_CMD;
            end
            usart_cmd_pkg::PH_SYNC2: begin
               s_nxt.sync2 = s_r.wdata;
               s_nxt.phase = usart_cmd_pkg::PH_CMD;
            end
            usart_cmd_pkg::PH_CMD: begin
               if (s_r.wdata[usart_cmd_pkg::CMD_IR_BIT]) begin
                  // Internal reset clears the command word and error flags, not only the phase
                  s_nxt.phase = usart_cmd_pkg::PH_MODE; // [R9] [R2]
                  s_nxt.cmd   = usart_cmd_pkg::BYTE_RST;
                  s_nxt.pe    = 1'b0;
                  s_nxt.oe    = 1'b0;
                  s_nxt.fe    = 1'b0;
               end else begin
                  s_nxt.cmd  = s_r.wdata; // [R1] [R3]
                  s_nxt.hunt = s_r.wdata[usart_cmd_pkg::CMD_EH_BIT] & sync_mode;
               end
            end
         endcase
      end

      if (wr_end && !s_r.wr_cd) begin
         s_nxt.tx_data   = s_r.wdata; // [R13]
         s_nxt.tx_load   = 1'b1;
         s_nxt.buf_empty = 1'b0;
      end

      if (parity_err_i) begin
         s_nxt.pe = 1'b1;
      end
      if (overrun_err_i) begin
         s_nxt.oe = 1'b1;
      end
      if (framing_err_i) begin
         s_nxt.fe = 1'b1;
      end

      s_nxt.dtr_n = ~s_nxt.cmd[usart_cmd_pkg::CMD_DTR_BIT]; // [R3]
      s_nxt.rts_n = ~s_nxt.cmd[usart_cmd_pkg::CMD_RTS_BIT]; // [R3]

      // Pins and status share sources; only the buffer-ready pin is gated
      s_nxt.rxrdy_pin = rx_ready_i;
      s_nxt.txe_pin   = tx_empty_i;
      s_nxt.syn_pin   = sync_detect_i;
      s_nxt.tx_buffer_ready_pin = s_nxt.buf_empty & ~cts_n_i &
                        s_nxt.cmd[usart_cmd_pkg::CMD_TXEN_BIT]; // [R7]

      // Snapshot tracks every idle cycle, so the lag stays far below 28 clocks
      if (!rd_now) begin
         s_nxt.status[usart_cmd_pkg::STAT_TX_BUFFER_READY_BIT] = s_nxt.buf_empty; // [R7] [R6]
         s_nxt.status[usart_cmd_pkg::STAT_RXRDY_BIT] = rx_ready_i; // [R7]
         s_nxt.status[usart_cmd_pkg::STAT_TXE_BIT]   = tx_empty_i; // [R7]
         s_nxt.status[usart_cmd_pkg::STAT_PE_BIT]    = s_nxt.pe;
         s_nxt.status[usart_cmd_pkg::STAT_OE_BIT]    = s_nxt.oe;
         s_nxt.status[usart_cmd_pkg::STAT_FE_BIT]    = s_nxt.fe;
         s_nxt.status[usart_cmd_pkg::STAT_SYN_BIT]   = sync_detect_i; // [R7]
         s_nxt.status[usart_cmd_pkg::STAT_DSR_BIT]   = ~dsr_n_i;
      end // [R5]

      if (rd_now) begin
         s_nxt.rd_cd = bus_i.cd;
         s_nxt.rdata = bus_i.cd ? s_r.status : rx_data_i; // [R4] [R13]
         s_nxt.oe_n  = 1'b0;
      end else begin
         s_nxt.oe_n  = 1'b1;
      end

      // Side effects fire once, when the read strobe ends
      if (rd_end) begin
         s_nxt.stat_read = s_r.rd_cd;
         s_nxt.rx_read   = ~s_r.rd_cd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         s_r <= usart_cmd_pkg::STATE_RST; // [R2]
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign data_o            = s_r.rdata;
   assign data_oe_n_o       = s_r.oe_n;
   assign mode_word_o       = s_r.mode;
   assign sync1_o           = s_r.sync1;
   assign sync2_o           = s_r.sync2;
   assign tx_data_o         = s_r.tx_data;
   assign tx_load_o         = s_r.tx_load;
   assign rx_read_o         = s_r.rx_read;
   assign status_read_o     = s_r.stat_read;
   assign enter_hunt_o      = s_r.hunt;
   assign tx_enable_o       = s_r.cmd[usart_cmd_pkg::CMD_TXEN_BIT];
   assign rx_enable_o       = s_r.cmd[usart_cmd_pkg::CMD_RXEN_BIT];
   assign send_break_o      = s_r.cmd[usart_cmd_pkg::CMD_SBRK_BIT];
   assign dtr_n_o           = s_r.dtr_n;
   assign rts_n_o           = s_r.rts_n;
   assign tx_buffer_ready_o = s_r.tx_buffer_ready_pin;
   assign rx_ready_o        = s_r.rxrdy_pin;
   assign tx_empty_o        = s_r.txe_pin;
   assign sync_detect_o     = s_r.syn_pin;

endmodule

/* File: hw/usart_cmd_pkg.sv */
package usart_cmd_pkg;

   localparam int DATA_W = 8;

   // Mode word fields used by the control path
   localparam int         MODE_BAUD_LSB  = 0;
   localparam logic [1:0] MODE_BAUD_SYNC = 2'h0;
   localparam int         MODE_SCS_BIT   = 7;

   // Command word fields
   localparam int CMD_TXEN_BIT = 0;
   localparam int CMD_DTR_BIT  = 1;
   localparam int CMD_RXEN_BIT = 2;
   localparam int CMD_SBRK_BIT = 3;
   localparam int CMD_ER_BIT   = 4;
   localparam int CMD_RTS_BIT  = 5;
   localparam int CMD_IR_BIT   = 6;
   localparam int CMD_EH_BIT   = 7;

   // Status byte fields
   localparam int STAT_TX_BUFFER_READY_BIT = 0;
   localparam int STAT_RXRDY_BIT = 1;
   localparam int STAT_TXE_BIT   = 2;
   localparam int STAT_PE_BIT    = 3;
   localparam int STAT_OE_BIT    = 4;
   localparam int STAT_FE_BIT    = 5;
   localparam int STAT_SYN_BIT   = 6;
   localparam int STAT_DSR_BIT   = 7;

   localparam logic [7:0] BYTE_RST = 8'h00;

   typedef enum logic [1:0] {
      PH_MODE,
      PH_SYNC1,
      PH_SYNC2,
      PH_CMD
   } phase_type;

   typedef struct packed {
      logic       cs_n;
      logic       rd_n;
      logic       wr_n;
      logic       cd;
      logic [7:0] data;
   } host_bus_type;

   typedef struct packed {
      phase_type  phase;
      logic [7:0] mode;
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [7:0] cmd;
      logic [7:0] tx_data;
      logic [7:0] status;
      logic [7:0] rdata;
      logic [7:0] wdata;
      logic       wr_act;
      logic       wr_cd;
      logic       rd_act;
      logic       rd_cd;
      logic       buf_empty;
      logic       pe;
      logic       oe;
      logic       fe;
      logic       tx_load;
      logic       rx_read;
      logic       stat_read;
      logic       hunt;
      logic       oe_n;
      logic       dtr_n;
      logic       rts_n;
      logic       tx_buffer_ready_pin;
      logic       rxrdy_pin;
      logic       txe_pin;
      logic       syn_pin;
   } state_type;

   localparam state_type STATE_RST = '{
      phase:     PH_MODE,
      buf_empty: 1'b1,
      oe_n:      1'b1,
      dtr_n:     1'b1,
      rts_n:     1'b1,
      default:   '0
   };

endpackage

/* File: test/usart_port_asserts.sv */
`timescale 1ns/10ps
module usart_port_asserts (
   input wire logic                        clk_sys_i,
   input wire logic                        rst_n_i,
   input wire usart_cmd_pkg::host_bus_type bus_i,
   input wire logic                        rx_ready_i,
   input wire logic [7:0]                  data_o,
   input wire logic                        data_oe_n_o,
   input wire logic                        status_read_o,
   input wire logic                        rx_read_o,
   input wire logic                        tx_load_o,
   input wire logic                        enter_hunt_o,
   input wire logic                        rx_ready_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   wire rd = !bus_i.cs_n && !bus_i.rd_n;
   wire wr = !bus_i.cs_n && !bus_i.wr_n;
   wire stat_rd = rd && bus_i.cd;
   a_read_drives: assert property (rd |=> !data_oe_n_o)
      else $error("read not driven");
   a_read_floats: assert property (!rd && $past(!rd) |=> data_oe_n_o)
      else $error("bus held after read");
   a_stat_frozen: assert property (stat_rd && $past(stat_rd) |=> $stable(data_o))
      else $error("status moved in read");
   a_stat_pulse: assert property ($past(rd && bus_i.cd) && !rd |-> ##[0:2] status_read_o)
      else $error("no status read pulse");
   a_rx_pulse: assert property ($past(rd && !bus_i.cd) && !rd |-> ##[0:2] rx_read_o)
      else $error("no receive read pulse");
   a_rx_mirror: assert property ($past(rst_n_i) |-> rx_ready_o == $past(rx_ready_i))
      else $error("rx ready mirror wrong");
   a_load_pulse: assert property ($past(wr && !bus_i.cd) && !wr |-> ##[0:2] tx_load_o)
      else $error("no transmit load");
   a_load_single: assert property (tx_load_o |=> !tx_load_o)
      else $error("load pulse too long");
   a_hunt_single: assert property (enter_hunt_o |=> !enter_hunt_o)
      else $error("hunt pulse too long");
   c_stat_read: cover property (status_read_o);
   c_rx_read: cover property (rx_read_o);
   c_load: cover property (tx_load_o);
   c_hunt: cover property (enter_hunt_o);
endmodule
////////////////////////////////////////////////////////////
bind usart_command_status_port usart_port_asserts chk_u (
   .clk_sys_i, .rst_n_i, .bus_i, .rx_ready_i, .data_o, .data_oe_n_o,
   .status_read_o, .rx_read_o, .tx_load_o, .enter_hunt_o, .rx_ready_o);

/* File: test/host_cpu_model.sv */
`timescale 1ns/10ps
module host_cpu_model (
   input  wire logic                   clk_sys_i,
   input  wire logic [7:0]             data_i,
   output usart_cmd_pkg::host_bus_type bus_o
);
   initial bus_o = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00};
   // Sixteen idle clocks meets every recovery gap; released data is inverted so it never lingers
   task automatic wr(input logic cd, input logic [7:0] d);
      bus_o = '{1'b0, 1'b1, 1'b0, cd, d};
      @(negedge clk_sys_i);
      bus_o = '{1'b1, 1'b1, 1'b1, cd, ~d};
      repeat (16) @(negedge clk_sys_i);
   endtask
   task automatic rd(input logic cd, output logic [7:0] d);
      bus_o = '{1'b0, 1'b0, 1'b1, cd, ~bus_o.data};
      repeat (4) @(negedge clk_sys_i);
      d = data_i;
      bus_o = '{1'b1, 1'b1, 1'b1, cd, ~bus_o.data};
      repeat (16) @(negedge clk_sys_i);
   endtask
endmodule

/* File: test/tb_usart_command_status_port.sv */
`timescale 1ns/10ps
module tb_usart_command_status_port;
   logic                        clk_sys_i = 1'b0, rst_n_i = 1'b0, tx_taken_i = 1'b0;
   logic                        rx_ready_i = 1'b0, tx_empty_i = 1'b0, sync_detect_i = 1'b0;
   logic                        parity_err_i = 1'b0, overrun_err_i = 1'b0, framing_err_i = 1'b0;
   logic                        dsr_n_i = 1'b1, cts_n_i = 1'b1, data_oe_n_o, tx_enable_o;
   logic                        rx_enable_o, send_break_o, dtr_n_o, rts_n_o, tx_buffer_ready_o;
   logic [7:0]                  rx_data_i = 8'h00, v, data_o, mode_word_o;
   logic [7:0]                  sync1_o, sync2_o, tx_data_o;
   logic                        rx_ready_o, tx_empty_o, sync_detect_o;
   usart_cmd_pkg::host_bus_type bus_i;
   int                          checked = 0, miscompares = 0;
   usart_command_status_port dut_u (
      .clk_sys_i, .rst_n_i, .bus_i, .rx_data_i, .rx_ready_i, .tx_empty_i, .tx_taken_i,
      .parity_err_i, .overrun_err_i, .framing_err_i, .sync_detect_i, .dsr_n_i, .cts_n_i,
      .data_o, .data_oe_n_o, .mode_word_o, .sync1_o, .sync2_o, .tx_data_o, .tx_load_o(),
      .rx_read_o(), .status_read_o(), .enter_hunt_o(), .tx_enable_o, .rx_enable_o,
      .send_break_o, .dtr_n_o, .rts_n_o, .tx_buffer_ready_o, .rx_ready_o, .tx_empty_o,
      .sync_detect_o);
   host_cpu_model host_u (.clk_sys_i, .data_i(data_o), .bus_o(bus_i));
   initial forever #12.5 clk_sys_i = ~clk_sys_i;
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic t_reset();
      check(8'({data_oe_n_o, dtr_n_o, rts_n_o, tx_enable_o}), 8'h0e);
   endtask
   task automatic t_cmd();
      host_u.wr(1'b1, 8'h4e);
      check(mode_word_o, 8'h4e);
      host_u.wr(1'b1, 8'h0a);
      check(8'({rts_n_o, send_break_o, rx_enable_o, dtr_n_o, tx_enable_o}), 8'h18);
      host_u.wr(1'b1, 8'h27);
      check(8'({rts_n_o, send_break_o, rx_enable_o, dtr_n_o, tx_enable_o}), 8'h05);
      check(mode_word_o, 8'h4e);
   endtask
   task automatic t_status();
      {rx_ready_i, tx_empty_i, sync_detect_i, dsr_n_i, cts_n_i} = 5'h1c;
      {parity_err_i, overrun_err_i, framing_err_i} = 3'h7;
      @(negedge clk_sys_i);
      {parity_err_i, overrun_err_i, framing_err_i} = 3'h0;
      // Read starts only once the 28-clock deadline for the flags has run out
      repeat (27) @(negedge clk_sys_i);
      check(8'({rx_ready_o, tx_empty_o, sync_detect_o}), 8'h07);
      host_u.rd(1'b1, v);
      check(v, 8'hff);
      host_u.wr(1'b1, 8'h37);
      // A parity event in mid-read must not reach the byte being read
      fork
         host_u.rd(1'b1, v);
         begin
            repeat (2) @(negedge clk_sys_i);
            parity_err_i = 1'b1;
            @(negedge clk_sys_i);
            parity_err_i = 1'b0;
         end
      join
      check(v, 8'hc7);
      host_u.rd(1'b1, v);
      check(v, 8'hcf);
   endtask
   task automatic t_data();
      check(tx_buffer_ready_o, 8'h01);
      host_u.wr(1'b0, 8'h5a);
      check(tx_data_o, 8'h5a);
      check(tx_buffer_ready_o, 8'h00);
      tx_taken_i = 1'b1;
      @(negedge clk_sys_i);
      tx_taken_i = 1'b0;
      @(negedge clk_sys_i);
      check(tx_buffer_ready_o, 8'h01);
      rx_data_i = 8'hc3;
      host_u.rd(1'b0, v);
      check(v, 8'hc3);
   endtask
   task automatic t_sync();
      host_u.wr(1'b1, 8'h40);
      check(tx_enable_o, 8'h00);
      host_u.wr(1'b1, 8'h00);
      check(mode_word_o, 8'h00);
      host_u.wr(1'b1, 8'h16);
      host_u.wr(1'b1, 8'h17);
      host_u.wr(1'b1, 8'h81);
      check(sync1_o, 8'h16);
      check(8'({sync2_o == 8'h17, tx_enable_o}), 8'h03);
      // Single sync character: the command follows the first sync byte directly
      host_u.wr(1'b1, 8'h40);
      host_u.wr(1'b1, 8'h80);
      host_u.wr(1'b1, 8'h33);
      host_u.wr(1'b1, 8'h05);
      check(sync1_o, 8'h33);
      check(8'({sync2_o == 8'h17, rx_enable_o, tx_enable_o}), 8'h07);
   endtask
   task automatic t_ext_reset();
      rst_n_i = 1'b0;
      repeat (6) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      t_reset();
      host_u.wr(1'b1, 8'h4e);
      check(mode_word_o, 8'h4e);
   endtask
   initial begin
      repeat (2) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      t_reset();
      t_cmd();
      t_status();
      t_data();
      t_sync();
      t_ext_reset();
      wrap_up();
   end
   initial begin
      repeat (5000) @(posedge clk_sys_i);
      miscompares++;
      wrap_up();
   end
endmodule
